// File: hw/eps_core.sv
`timescale 1ns/1ps
`include "eps_defines.svh"

module eps_core (
    // Clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Access port
    input wire logic [`EPS_AW-1:0] addr,
    input wire logic re,
    input wire logic we,
    input wire logic [`EPS_CW-1:0] wdata,
    output logic [`EPS_CW-1:0] rdata
);

    // Array has no reset; stored text survives a sequencer reset
    logic [`EPS_CW-1:0] mem [0:`EPS_DEPTH-1];

    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= `EPS_CHAR_RST;
        end else if (ce && re) begin
            rdata <= mem[addr];
        end
    end

endmodule : eps_core

// File: hw/eps_seq.sv
`timescale 1ns/1ps
`include "eps_defines.svh"

// How it works
// - Final push cycle phase 4 clears push, dropping edit request.
// - Push-by-one over end marker: cursor counts up once at finish.
// - Completion sets done latch, pulses load complete, clears keyboard busy.
// - Keyboard lockout holds until next display end pulse after edit.
// - One-by-two replace shifts all text through end marker one place.
// - One-by-two: first two cycles cursor addressed, rest memory address.
// - Two-position key over data sets replace1_insert2, starting first cycle.
// - First one-by-two cycle loads prefix at phase 1, writes it.
// - Its phase 4 clears replace1_insert2, sets insert_one, counts cursor.
// - Second cycle phase 1 loads key and copies cursor to memaddr.
// - Second cycle phase 4 clears insert_one, sets push, counts memaddr.
// - Late phase 5 of shifting cycles moves read register to display.
// - One-by-two push cycles write display at phase 4, count memaddr at 4.
// - End marker read during push sets last-cycle flag at phase 4.
// - Final one-by-two cycle writes end marker, clears push, counts cursor.
// - Push-by-two takes three cycles: cursor first, memaddr for two.
// - Two-position key over end marker sets insert_two, cursor addressing.
// - Push-by-two phase 1 loads prefix to buffer, clears memaddr.
// - Push-by-two drives buffer, not display, onto write lines.
// - After each push-by-two write but the last: display to buffer, read to display.
// - Third push-by-two cycle writes end marker from buffer.
// - A fixed code group is two-position: prefix then character.
// - Keyboard busy refuses strobes from every keyboard.

module eps_seq (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Keyboards
    input wire logic key_strobe,
    input wire logic [1:0] key_sel,
    input wire logic [`EPS_CW-1:0] key_code,
    output logic key_accept,
    output logic key_refused,
    output logic key_load_complete,
    output logic keyboard_busy,
    output logic [`EPS_NKBD-1:0] kbd_lockout_flag,
    // Control storage and display timing
    input wire logic cursor_on_data,
    input wire logic cursor_on_end,
    input wire logic display_end_pulse,
    // Sequencer status
    output logic edit_request,
    output logic addr_from_cursor,
    output logic addr_from_memreg,
    output eps_pkg::eps_phase_e edit_phase
);
    import eps_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic eps_addr_t eps_inc(input eps_addr_t a, input logic [1:0] k);
        return a + {{(`EPS_AW-2){1'b0}}, k};
    endfunction : eps_inc

    function automatic logic eps_is_two_pos(input eps_char_t c);
        return c[`EPS_CW-1:`EPS_TWOPOS_LSB] == `EPS_TWOPOS_GROUP;
    endfunction : eps_is_two_pos

    function automatic logic eps_is_end(input eps_char_t c);
        return c == `EPS_END_MARKER;
    endfunction : eps_is_end

    function automatic logic eps_edit_pending(input eps_state_s s);
        return s.replace1_insert2_ff || s.insert_one_ff || s.insert_two_ff || s.push_active;
    endfunction : eps_edit_pending

    function automatic logic eps_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : eps_hit

    // Field order must match the status map that software reads
    function automatic logic [31:0] eps_status_word(input eps_state_s s);
        return {17'h0, s.kbd_lockout_flag, s.last_cycle, s.buffer_drive_ff,
                s.push_active, s.insert_two_ff, s.insert_one_ff,
                s.replace1_insert2_ff, s.push_done_latch,
                s.keyboard_busy_ff, s.phase};
    endfunction : eps_status_word

    // ----------------------------------------
    // State
    // ----------------------------------------
    eps_state_s r;
    eps_state_s n;

    logic two_pos;
    logic idle;
    logic edit_req_next;
    logic mem_re;
    logic mem_we;
    eps_addr_t mem_addr;
    eps_addr_t edit_addr;
    eps_char_t mem_wdata;
    eps_char_t mem_rdata;
    logic sw_mem_wr;
    logic sw_mem_rd;

    // ----------------------------------------
    // Core memory
    // ----------------------------------------
    eps_core u_core (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .addr(mem_addr),
        .re(mem_re),
        .we(mem_we),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // ----------------------------------------
    // Memory steering
    // ----------------------------------------
    // Single-ported core: the sequencer owns it from PH_1 to PH_5E
    assign idle = (r.phase == PH_IDLE);
    assign edit_addr = r.push_active ? r.memaddr : r.cursor;
    // Software gets the core only between edits
    assign sw_mem_wr = idle && !r.keyboard_busy_ff && reg_wr && eps_hit(reg_addr, `EPS_REG_MEMDATA);
    assign sw_mem_rd = idle && reg_rd && eps_hit(reg_addr, `EPS_REG_MEMDATA);
    assign mem_addr = idle ? r.cursor : edit_addr;
    // Read launched at PH_1 lands in the read register at PH_2
    assign mem_re = (r.phase == PH_1) || sw_mem_rd;
    // One write clock per cycle, at the PH_4 edge
    assign mem_we = (r.phase == PH_4) || sw_mem_wr;

    // ----------------------------------------
    // Memory write data
    // ----------------------------------------
    // Push-by-two writes from the buffer so the display can carry the next word
    always_comb begin
        if (idle) begin
            mem_wdata = reg_wdata[`EPS_CW-1:0];
        end else if (r.buffer_drive_ff) begin
            mem_wdata = r.bufr;
        end else begin
            mem_wdata = r.disp;
        end
    end

    // ----------------------------------------
    // Keyboard gate
    // ----------------------------------------
    assign two_pos = eps_is_two_pos(key_code);
    // Busy blocks all keyboards; lockout blocks only the editing one
    assign key_accept = key_strobe && !r.keyboard_busy_ff && !r.kbd_lockout_flag[key_sel];
    assign key_refused = key_strobe && !key_accept;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = r;
        n.key_load_complete = 1'b0;
        n.rd_mem = 1'b0;
        n.rdata = 32'h0;

        // Lockout ends with the display pass after the edit
        if (display_end_pulse && !r.keyboard_busy_ff) begin
            n.kbd_lockout_flag = '0;
        end

        if (key_accept) begin
            n.keyboard_busy_ff = 1'b1;
            n.kbd_lockout_flag[key_sel] = 1'b1;
            n.push_done_latch = 1'b0;
            n.key = key_code;
            if (two_pos && cursor_on_end) begin
                n.insert_two_ff = 1'b1;
            end else if (two_pos && cursor_on_data) begin
                n.replace1_insert2_ff = 1'b1;
            end else if (!two_pos && cursor_on_end) begin
                n.insert_one_ff = 1'b1;
            end else begin
                // Equal replace is handled elsewhere; release at once
                n.keyboard_busy_ff = 1'b0;
                n.push_done_latch = 1'b1;
                n.key_load_complete = 1'b1;
            end
        end

        case (r.phase)
            PH_IDLE: begin
                if (edit_request) begin
                    n.phase = PH_1;
                end
            end
            PH_1: begin
                if (r.replace1_insert2_ff) begin
                    n.disp = `EPS_PREFIX_CODE;
                end else if (r.insert_one_ff) begin
                    n.disp = r.key;
                    n.memaddr = r.cursor;
                end else if (r.insert_two_ff) begin
                    n.bufr = `EPS_PREFIX_CODE;
                    n.buffer_drive_ff = 1'b1;
                    n.memaddr = `EPS_MEMADDR_RST;
                end
                n.phase = PH_2;
            end
            PH_2: begin
                n.core_read_reg = mem_rdata;
                // Prefix already waits in the buffer; display takes the key
                if (r.insert_two_ff) begin
                    n.disp = r.key;
                    n.memaddr = r.cursor;
                end
                n.phase = PH_3;
            end
            PH_3: begin
                n.phase = PH_4;
            end
            PH_4: begin
                if (r.replace1_insert2_ff) begin
                    n.replace1_insert2_ff = 1'b0;
                    n.insert_one_ff = 1'b1;
                    n.cursor = eps_inc(r.cursor, 2'h1);
                end else if (r.insert_one_ff) begin
                    n.insert_one_ff = 1'b0;
                    n.push_active = 1'b1;
                    n.memaddr = eps_inc(r.memaddr, 2'h1);
                    // End marker already sits in the read register: one write to go
                    if (eps_is_end(r.core_read_reg)) begin
                        n.last_cycle = 1'b1;
                    end
                end else if (r.insert_two_ff) begin
                    n.insert_two_ff = 1'b0;
                    n.push_active = 1'b1;
                    n.memaddr = eps_inc(r.memaddr, 2'h1);
                    // Two more cycles follow before the end marker lands
                    n.hold_two = 1'b1;
                end else if (r.push_active) begin
                    // Counted on the last cycle too, where the value goes unused
                    n.memaddr = eps_inc(r.memaddr, 2'h1);
                    if (r.last_cycle) begin
                        n.push_active = 1'b0;
                        n.last_cycle = 1'b0;
                        n.buffer_drive_ff = 1'b0;
                        // Push-by-two steps past both positions
                        n.cursor = eps_inc(r.cursor, r.buffer_drive_ff ? 2'h2 : 2'h1);
                        n.push_done_latch = 1'b1;
                        n.key_load_complete = 1'b1;
                        n.keyboard_busy_ff = 1'b0;
                    end else if (r.hold_two || eps_is_end(r.core_read_reg)) begin
                        n.last_cycle = 1'b1;
                        n.hold_two = 1'b0;
                    end
                end
                n.phase = PH_5;
            end
            PH_5: begin
                n.phase = PH_5E;
            end
            PH_5E: begin
                if (r.push_active) begin
                    n.disp = r.core_read_reg;
                    if (r.buffer_drive_ff) begin
                        n.bufr = r.disp;
                    end
                end
                n.phase = edit_req_next ? PH_1 : PH_IDLE;
            end
            default: begin
                n.phase = PH_IDLE;
            end
        endcase

        // ----------------------------------------
        // Register port
        // ----------------------------------------
        // Cursor belongs to the sequencer while an edit runs
        if (reg_wr && !r.keyboard_busy_ff && idle && eps_hit(reg_addr, `EPS_REG_CURSOR)) begin
            n.cursor = reg_wdata[`EPS_AW-1:0];
        end
        // Read data stand for one cycle, then fall back to zero
        if (reg_rd) begin
            n.rd_mem = sw_mem_rd;
            case (reg_addr)
                `EPS_REG_STATUS: begin
                    n.rdata = eps_status_word(r);
                end
                `EPS_REG_CURSOR: begin
                    n.rdata = {22'h0, r.cursor};
                end
                `EPS_REG_MEMADDR: begin
                    n.rdata = {22'h0, r.memaddr};
                end
                `EPS_REG_DATAPATH: begin
                    n.rdata = {8'h0, r.key, r.bufr, r.disp, r.core_read_reg};
                end
                default: begin
                    n.rdata = 32'h0;
                end
            endcase
        end
    end

    // Next flags decide whether PH_5E chains straight into PH_1
    assign edit_req_next = eps_edit_pending(n);

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            // Core array keeps its text; only sequencer state clears
            r <= '0;
            r.phase <= PH_IDLE;
            r.cursor <= `EPS_CURSOR_RST;
            r.memaddr <= `EPS_MEMADDR_RST;
        end else if (ce) begin
            r <= n;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Request falls with the flags at phase 4; the cycle still runs out
    assign edit_request = eps_edit_pending(r);
    assign addr_from_cursor = edit_request && !r.push_active;
    assign addr_from_memreg = r.push_active;
    assign edit_phase = r.phase;
    assign keyboard_busy = r.keyboard_busy_ff;
    assign kbd_lockout_flag = r.kbd_lockout_flag;
    assign key_load_complete = r.key_load_complete;
    assign reg_rdata = r.rd_mem ? {{(32-`EPS_CW){1'b0}}, mem_rdata} : r.rdata;

endmodule : eps_seq

// File: shared/eps_defines.svh
`ifndef EPS_DEFINES_SVH
`define EPS_DEFINES_SVH

// ----------------------------------------
// Widths and sizes
// ----------------------------------------
`define EPS_AW 10
`define EPS_DEPTH 1024
`define EPS_CW 6
`define EPS_NKBD 4

// ----------------------------------------
// Character codes
// ----------------------------------------
`define EPS_PREFIX_CODE 6'h3e
`define EPS_END_MARKER 6'h3f
`define EPS_TWOPOS_GROUP 3'h6
`define EPS_TWOPOS_LSB 3

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EPS_REG_STATUS 8'h00
`define EPS_REG_CURSOR 8'h04
`define EPS_REG_MEMADDR 8'h08
`define EPS_REG_DATAPATH 8'h0c
`define EPS_REG_MEMDATA 8'h10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EPS_CURSOR_RST 10'h000
`define EPS_MEMADDR_RST 10'h000
`define EPS_CHAR_RST 6'h00

`endif

// File: shared/eps_pkg.sv
`include "eps_defines.svh"

package eps_pkg;

    // ----------------------------------------
    // Core cycle phases
    // ----------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_1,
        PH_2,
        PH_3,
        PH_4,
        PH_5,
        PH_5E
    } eps_phase_e;

    typedef logic [`EPS_AW-1:0] eps_addr_t;
    typedef logic [`EPS_CW-1:0] eps_char_t;

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    typedef struct packed {
        eps_phase_e phase;
        logic replace1_insert2_ff;
        logic insert_one_ff;
        logic insert_two_ff;
        logic push_active;
        logic last_cycle;
        logic hold_two;
        logic buffer_drive_ff;
        logic push_done_latch;
        logic keyboard_busy_ff;
        logic key_load_complete;
        logic [`EPS_NKBD-1:0] kbd_lockout_flag;
        eps_addr_t cursor;
        eps_addr_t memaddr;
        eps_char_t key;
        eps_char_t disp;
        eps_char_t bufr;
        eps_char_t core_read_reg;
        logic rd_mem;
        logic [31:0] rdata;
    } eps_state_s;

endpackage : eps_pkg

// File: tb/eps_disp_model.sv
`timescale 1ns/1ps

module eps_disp_model #(
    parameter int PERIOD = 64
) (
    // Clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    // Display timing
    output logic display_end_pulse
);
    int cnt_reg;
    // Frames only while enabled, so lockout release stays under bench control
    always_ff @(posedge clk) begin
        if (srst || !run) begin
            cnt_reg <= 0;
            display_end_pulse <= 1'b0;
        end else begin
            cnt_reg <= (cnt_reg == PERIOD - 1) ? 0 : cnt_reg + 1;
            display_end_pulse <= (cnt_reg == PERIOD - 1);
        end
    end
endmodule : eps_disp_model

// File: tb/eps_seq_chk_sva.sv
`timescale 1ns/1ps
`include "eps_defines.svh"

module eps_seq_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Keyboards
    input wire logic key_strobe,
    input wire logic key_accept,
    input wire logic key_refused,
    input wire logic key_load_complete,
    input wire logic keyboard_busy,
    input wire logic [`EPS_NKBD-1:0] kbd_lockout_flag,
    input wire logic display_end_pulse,
    // Status
    input wire logic edit_request,
    input wire logic addr_from_cursor,
    input wire logic addr_from_memreg,
    input wire eps_pkg::eps_phase_e edit_phase
);
    import eps_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    property p_refuse;
        key_strobe && keyboard_busy |-> key_refused && !key_accept;
    endproperty
    a_refuse: assert property (p_refuse) else $error("key taken while busy");
    property p_start;
        key_accept |=> keyboard_busy || key_load_complete;
    endproperty
    a_start: assert property (p_start) else $error("accepted key started nothing");
    property p_done;
        key_load_complete |-> !keyboard_busy && !edit_request;
    endproperty
    a_done: assert property (p_done) else $error("busy left after completion");
    property p_done_at;
        key_load_complete |-> $past(edit_phase) == PH_4 || $past(key_accept);
    endproperty
    a_done_at: assert property (p_done_at) else $error("completion off phase 4");
    property p_phases;
        edit_phase == PH_1 |=> edit_phase == PH_2 ##1 edit_phase == PH_3 ##1 edit_phase == PH_4
            ##1 edit_phase == PH_5 ##1 edit_phase == PH_5E;
    endproperty
    a_phases: assert property (p_phases) else $error("phase order broken");
    property p_addr;
        !(addr_from_cursor && addr_from_memreg);
    endproperty
    a_addr: assert property (p_addr) else $error("two address sources");
    property p_push_set;
        $rose(addr_from_memreg) |-> $past(edit_phase) == PH_4;
    endproperty
    a_push_set: assert property (p_push_set) else $error("push set off phase 4");
    property p_push_end;
        $fell(addr_from_memreg) |-> key_load_complete;
    endproperty
    a_push_end: assert property (p_push_end) else $error("push ended without completion");
    property p_lock;
        |($past(kbd_lockout_flag) & ~kbd_lockout_flag) |-> $past(display_end_pulse) && !$past(keyboard_busy);
    endproperty
    a_lock: assert property (p_lock) else $error("lockout cleared early");
endmodule : eps_seq_chk

bind eps_seq eps_seq_chk u_chk (.clk(clk), .srst(srst), .key_strobe(key_strobe), .key_accept(key_accept),
    .key_refused(key_refused), .key_load_complete(key_load_complete), .keyboard_busy(keyboard_busy),
    .kbd_lockout_flag(kbd_lockout_flag), .display_end_pulse(display_end_pulse), .edit_request(edit_request),
    .addr_from_cursor(addr_from_cursor), .addr_from_memreg(addr_from_memreg), .edit_phase(edit_phase));

// File: tb/eps_seq_test.sv
`timescale 1ns/1ps
`include "eps_defines.svh"

module eps_seq_test;
    import eps_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic key_strobe = 1'b0;
    logic [1:0] key_sel = 2'h0;
    logic [5:0] key_code = 6'h00;
    logic key_accept, key_refused, key_load_complete, keyboard_busy;
    logic [3:0] kbd_lockout_flag;
    logic cursor_on_data = 1'b0;
    logic cursor_on_end = 1'b0;
    logic disp_run = 1'b0;
    logic display_end_pulse, edit_request, addr_from_cursor, addr_from_memreg;
    eps_phase_e edit_phase;
    int n_errors = 0;
    int checked = 0;
    int n_mcyc = 0;
    logic [31:0] rd;

    always #20 clk = ~clk;
    always @(posedge clk) if (edit_phase == PH_1) n_mcyc <= n_mcyc + 1;

    eps_seq uut (.clk(clk), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_strobe(key_strobe), .key_sel(key_sel),
        .key_code(key_code), .key_accept(key_accept), .key_refused(key_refused),
        .key_load_complete(key_load_complete), .keyboard_busy(keyboard_busy),
        .kbd_lockout_flag(kbd_lockout_flag), .cursor_on_data(cursor_on_data), .cursor_on_end(cursor_on_end),
        .display_end_pulse(display_end_pulse), .edit_request(edit_request),
        .addr_from_cursor(addr_from_cursor), .addr_from_memreg(addr_from_memreg), .edit_phase(edit_phase));
    eps_disp_model u_disp (.clk(clk), .srst(srst), .run(disp_run), .display_end_pulse(display_end_pulse));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read
    task automatic mem_chk(input logic [9:0] a, input logic [5:0] c);
        reg_write(`EPS_REG_CURSOR, {22'h0, a});
        reg_read(`EPS_REG_MEMDATA, rd);
        check(rd, {26'h0, c});
    endtask : mem_chk
    task automatic press(input logic [1:0] s, input logic [5:0] c, input logic ok);
        @(posedge clk);
        key_sel <= s;
        key_code <= c;
        key_strobe <= 1'b1;
        #1 check({key_accept, key_refused}, {ok, !ok});
        @(posedge clk);
        key_strobe <= 1'b0;
    endtask : press
    // Runs one edit; a second keyboard tries to cut in while it is busy
    task automatic edit(input logic [1:0] s, input logic [5:0] c, input int ncyc);
        int start;
        start = n_mcyc;
        press(s, c, 1'b1);
        repeat (3) @(posedge clk);
        press(s + 2'h1, 6'h01, 1'b0);
        for (int i = 0; i < 2000 && key_load_complete !== 1'b1; i++) @(posedge clk) #1;
        check(key_load_complete, 1'b1);
        check(keyboard_busy, 1'b0);
        check(n_mcyc - start, ncyc);
    endtask : edit
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        reg_read(`EPS_REG_STATUS, rd);
        check(rd, 32'h0);
        reg_write(`EPS_REG_STATUS, 32'h7fff);
        reg_read(`EPS_REG_STATUS, rd);
        check(rd, 32'h0);
        reg_read(8'h14, rd);
        check(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            reg_write(`EPS_REG_CURSOR, i);
            reg_write(`EPS_REG_MEMDATA, (i == 3) ? `EPS_END_MARKER : i + 1);
        end
        $display("test registers done");
        // Two-position key over B of A B C end
        cursor_on_data <= 1'b1;
        reg_write(`EPS_REG_CURSOR, 32'h1);
        edit(2'h0, 6'h31, 4);
        reg_read(`EPS_REG_CURSOR, rd);
        check(rd, 32'h3);
        mem_chk(10'h1, `EPS_PREFIX_CODE);
        mem_chk(10'h2, 6'h31);
        mem_chk(10'h3, 6'h03);
        mem_chk(10'h4, `EPS_END_MARKER);
        press(2'h0, 6'h01, 1'b0);
        disp_run <= 1'b1;
        for (int i = 0; i < 200 && display_end_pulse !== 1'b1; i++) @(posedge clk) #1;
        repeat (2) @(posedge clk);
        disp_run <= 1'b0;
        #1 check(kbd_lockout_flag[0], 1'b0);
        $display("test one_by_two done");
        // One-position key over the end marker
        @(posedge clk);
        cursor_on_data <= 1'b0;
        cursor_on_end <= 1'b1;
        reg_write(`EPS_REG_CURSOR, 32'h4);
        edit(2'h2, 6'h05, 2);
        reg_read(`EPS_REG_CURSOR, rd);
        check(rd, 32'h5);
        mem_chk(10'h4, 6'h05);
        mem_chk(10'h5, `EPS_END_MARKER);
        $display("test push_one_end done");
        // Two-position key over the end marker
        reg_write(`EPS_REG_CURSOR, 32'h5);
        edit(2'h3, 6'h32, 3);
        reg_read(`EPS_REG_CURSOR, rd);
        check(rd, 32'h7);
        mem_chk(10'h5, `EPS_PREFIX_CODE);
        mem_chk(10'h6, 6'h32);
        mem_chk(10'h7, `EPS_END_MARKER);
        $display("test push_two done");
        // Frozen clock enable: a cursor write must not land
        @(posedge clk);
        ce <= 1'b0;
        cursor_on_data <= 1'b1;
        cursor_on_end <= 1'b0;
        reg_write(`EPS_REG_CURSOR, 32'h9);
        ce <= 1'b1;
        reg_read(`EPS_REG_CURSOR, rd);
        check(rd, 32'h7);
        $display("test freeze done");
        // Equal replace finishes with no memory cycle
        press(2'h1, 6'h07, 1'b1);
        #1 check({key_load_complete, keyboard_busy}, 2'b10);
        $display("test equal done");
        stop_test();
    end
endmodule : eps_seq_test
